/* File: pcfg_pkg.sv */
// Constants, register map and carrier types of the paper and config control.
// Assumes a 20 MHz system clock and switch banks wired with bit 0 as switch 1.
package pcfg_pkg;

  // Clock and mechanism timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned CLK_PER_MS      = CLK_HZ / 1000;
  localparam int unsigned LOAD_TIME_MS    = 1000;  // Auto-load feed, about one second
  localparam int unsigned FEED_TIME_MS    = 300;
  localparam int unsigned CUT_TIME_MS     = 500;   // Cutter homing gives up after this
  localparam int unsigned EJECT_TIME_MS   = 800;

  // Register byte offsets
  localparam logic [7:0] OFS_STATUS       = 8'h00;
  localparam logic [7:0] OFS_CONFIG       = 8'h04;
  localparam logic [7:0] OFS_CONTROL      = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT     = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK     = 8'h10;

  // Switch positions (bit 0 is switch 1)
  localparam int unsigned SW1_CUTTER      = 0;
  localparam int unsigned SW1_DENSITY     = 2;
  localparam int unsigned SW1_XON         = 3;
  localparam int unsigned SW1_CODE_LO     = 4;
  localparam int unsigned SW2_LOW_EN      = 0;
  localparam int unsigned SW2_AUTOLOAD    = 3;
  localparam int unsigned SW2_DENSITY     = 5;
  localparam int unsigned SW2_DATA8       = 6;

  // Control register fields
  localparam int unsigned CTL_HOLD        = 0;
  localparam int unsigned CTL_FEED        = 1;

  // Interrupt bits
  localparam int unsigned IRQ_N           = 5;
  localparam int unsigned IRQ_PAPER_OUT   = 0;
  localparam int unsigned IRQ_PAPER_LOW   = 1;
  localparam int unsigned IRQ_TAKEN       = 2;
  localparam int unsigned IRQ_ALARM       = 3;
  localparam int unsigned IRQ_LOADED      = 4;

  // Reset values
  localparam logic [IRQ_N-1:0] RST_IRQ_MASK = 5'h00;
  localparam logic [1:0]  RST_CONTROL     = 2'h0;

  // Parity encodings
  localparam logic [1:0] PAR_NONE         = 2'h0;
  localparam logic [1:0] PAR_ODD          = 2'h1;
  localparam logic [1:0] PAR_EVEN         = 2'h2;

  // AXI responses
  localparam logic [1:0] RESP_OKAY        = 2'h0;
  localparam logic [1:0] RESP_SLVERR      = 2'h2;

  // Decoded power-on configuration
  typedef struct packed {
    logic       serial;
    logic [2:0] baud;     // 0:1200 1:2400 2:4800 3:9600 4:19200
    logic [1:0] parity;
    logic [1:0] density;
    logic       autoload;
    logic       low_en;
    logic       cutter_en;
    logic       xon_mode;
    logic       data8;
  } pcfg_cfg_t;

  // Host facing status pins
  typedef struct packed {
    logic busy;
    logic fault_n;
    logic paper_empty;
    logic dtr;
  } pcfg_host_t;

endpackage

/* File: pcfg_ctrl.sv */
// Paper status, power-on configuration and mechanism sequencing of a
// thermal printer with presenter, plus an AXI4-Lite register slave.
// Assumes all sensor inputs are synchronous to i_clock and debounced.
// What this block does
// - Parallel paper out: busy, fault, paper-empty, halt
// - Serial paper out: DTR busy, halt printing
// - Resume buffered data after new paper
// - Release paper-out indications once paper replaced and head lever down
// - Feed key: feed, cut, eject
// - Auto-load feeds fixed length, about one second
// - Auto-load switch off: never auto feed
// - Feed key at power-on runs self-print
// - Presenter ejects after every cut
// - Hold next job until paper taken
// - Switches sampled only at power-on
// - Cutter homing at power-on
// - Four-switch code: port, parity, baud
// - Two switches give density level
// - Near-end enabled and tripped: report low
// - Paper-empty high on out or low
// - Alarm: fault low, stop all control
//
// Local design decisions: the register offsets and the AXI4-Lite slave port.
module pcfg_ctrl
  import pcfg_pkg::*;
#(
  parameter int unsigned P_LOAD_CYCLES  = LOAD_TIME_MS * CLK_PER_MS,
  parameter int unsigned P_FEED_CYCLES  = FEED_TIME_MS * CLK_PER_MS,
  parameter int unsigned P_CUT_CYCLES   = CUT_TIME_MS * CLK_PER_MS,
  parameter int unsigned P_EJECT_CYCLES = EJECT_TIME_MS * CLK_PER_MS
) (
  input  wire logic        i_clock,
  input  wire logic        i_nrst,
  input  wire logic [7:0]  i_switch_bank_one,
  input  wire logic [7:0]  i_switch_bank_two,
  input  wire logic        i_paper_end,
  input  wire logic        i_paper_low_sensor,
  input  wire logic        i_head_lever_down,
  input  wire logic        i_feed_key,
  input  wire logic        i_cutter_home,
  input  wire logic        i_exit_paper,
  input  wire logic        i_alarm,
  input  wire logic        i_buffer_data,
  input  wire logic        i_cut_request,
  input  wire logic        i_print_done,
  output logic             o_busy,
  output logic             o_fault_n,
  output logic             o_paper_empty,
  output logic             o_dtr,
  output logic             o_print_enable,
  output logic             o_self_print,
  output logic             o_feed_motor,
  output logic             o_cutter_drive,
  output logic             o_presenter_drive,
  output pcfg_cfg_t        o_config,
  output logic             o_irq,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp
);

  typedef enum {ST_WAIT_CFG, ST_INIT_CUT, ST_SELF_PRINT, ST_IDLE, ST_PRINT, ST_PAPER_OUT,
                ST_LOAD, ST_FEED, ST_CUT, ST_EJECT, ST_WAIT_TAKE, ST_ALARM} pcfg_state_t;

  pcfg_state_t      state_ff, nxt_state;
  logic [31:0]      timer_ff;
  logic             cfg_taken_ff;
  logic             selftest_ff;
  pcfg_cfg_t        cfg_ff;
  pcfg_host_t       host_ff, nxt_host;
  logic [1:0]       control_ff;
  logic             feed_req_ff;
  logic [IRQ_N-1:0] irq_stat_ff, irq_mask_ff, irq_event;
  logic             paper_low, paper_out, low_seen_ff, out_seen_ff, exit_seen_ff;
  logic             aw_full_ff, w_full_ff, wr_fire, rd_fire;
  logic [7:0]       awaddr_ff;
  logic [31:0]      wdata_ff;
  logic [3:0]       wstrb_ff;

  // Switch code to port, parity and baud
  function automatic pcfg_cfg_t decode_cfg(input logic [7:0] s1, input logic [7:0] s2);
    pcfg_cfg_t  c;
    logic [3:0] code;
    logic [3:0] idx;
    c = '0;
    code = s1[SW1_CODE_LO +: 4];
    idx = code - 4'h1;
    c.serial = (code != 4'h0);
    if (code == 4'h0) begin
      c.parity = PAR_NONE;
      c.baud = 3'h0;
    end else if (idx < 4'h5) begin
      c.parity = PAR_NONE;
      c.baud = idx[2:0];
    end else if (idx < 4'hA) begin
      c.parity = PAR_ODD;
      c.baud = 3'(idx - 4'h5);
    end else begin
      c.parity = PAR_EVEN;
      c.baud = 3'(idx - 4'hA);
    end
    c.density   = {s1[SW1_DENSITY], s2[SW2_DENSITY]};
    c.autoload  = s2[SW2_AUTOLOAD];
    c.low_en    = s2[SW2_LOW_EN];
    c.cutter_en = s1[SW1_CUTTER];
    c.xon_mode  = s1[SW1_XON];
    c.data8     = s2[SW2_DATA8];
    return c;
  endfunction

  // Timed state expired
  function automatic logic expired(input logic [31:0] t, input int unsigned lim);
    return t >= (32'(lim) - 32'h1);
  endfunction

  // Switches caught once, first edge after reset release
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      cfg_taken_ff <= 1'b0;
      cfg_ff <= '0;
      selftest_ff <= 1'b0;
    end else if (!cfg_taken_ff) begin
      cfg_taken_ff <= 1'b1;
      cfg_ff <= decode_cfg(i_switch_bank_one, i_switch_bank_two);
      selftest_ff <= i_feed_key;
    end
  end

  assign paper_low = cfg_ff.low_en & i_paper_low_sensor;
  assign paper_out = i_paper_end;

  // Sequencer; alarm preempts every mechanism action, paper out every one except cutter homing
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      ST_WAIT_CFG:   if (cfg_taken_ff) nxt_state = ST_INIT_CUT;
      ST_INIT_CUT: begin
        if (i_cutter_home) nxt_state = selftest_ff ? ST_SELF_PRINT : ST_IDLE;
        else if (expired(timer_ff, P_CUT_CYCLES)) nxt_state = ST_ALARM; // Locked cutter
      end
      ST_SELF_PRINT: if (i_print_done) nxt_state = ST_CUT;
      ST_IDLE: begin
        if (feed_req_ff) nxt_state = ST_FEED;
        else if (i_buffer_data && !i_exit_paper && !control_ff[CTL_HOLD]) nxt_state = ST_PRINT;
      end
      ST_PRINT: begin
        if (i_cut_request) nxt_state = ST_CUT;
        else if (!i_buffer_data) nxt_state = ST_IDLE;
      end
      ST_PAPER_OUT: begin
        if (!paper_out && i_head_lever_down) begin
          if (cfg_ff.autoload && !i_paper_low_sensor) nxt_state = ST_LOAD;
          else nxt_state = ST_IDLE;
        end
      end
      ST_LOAD:       if (expired(timer_ff, P_LOAD_CYCLES)) nxt_state = ST_CUT;
      ST_FEED:       if (expired(timer_ff, P_FEED_CYCLES)) nxt_state = ST_CUT;
      ST_CUT: begin
        if (!cfg_ff.cutter_en) nxt_state = ST_IDLE;
        else if (expired(timer_ff, P_CUT_CYCLES)) nxt_state = ST_EJECT;
      end
      ST_EJECT:      if (expired(timer_ff, P_EJECT_CYCLES)) nxt_state = ST_WAIT_TAKE;
      ST_WAIT_TAKE:  if (!i_exit_paper) nxt_state = ST_IDLE;
      ST_ALARM:      nxt_state = ST_ALARM;
    endcase
    if (state_ff != ST_ALARM && state_ff != ST_WAIT_CFG && state_ff != ST_INIT_CUT
        && state_ff != ST_PAPER_OUT && paper_out) nxt_state = ST_PAPER_OUT;
    if (i_alarm && cfg_taken_ff) nxt_state = ST_ALARM;
  end

  // State and step timer
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      state_ff <= ST_WAIT_CFG;
      timer_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= (nxt_state != state_ff) ? 32'h0 : timer_ff + 32'h1;
    end
  end

  // Host status pins; held while the sensor reports no paper or the sequencer stays in paper out
  always_comb begin
    logic stop;
    stop = paper_out || nxt_state == ST_PAPER_OUT;
    nxt_host.busy        = !cfg_ff.serial && (stop || nxt_state == ST_ALARM || !cfg_taken_ff);
    nxt_host.fault_n     = !((stop && !cfg_ff.serial) || nxt_state == ST_ALARM);
    nxt_host.paper_empty = stop || paper_low;
    nxt_host.dtr         = cfg_ff.serial && (stop || nxt_state == ST_ALARM
                           || nxt_state == ST_SELF_PRINT);
  end

  // Drives all come from flops; alarm leaves every actuator off
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      host_ff <= '{busy: 1'b1, fault_n: 1'b1, paper_empty: 1'b0, dtr: 1'b0};
      o_print_enable <= 1'b0;
      o_self_print <= 1'b0;
      o_feed_motor <= 1'b0;
      o_cutter_drive <= 1'b0;
      o_presenter_drive <= 1'b0;
    end else begin
      host_ff <= nxt_host;
      o_print_enable <= (nxt_state == ST_PRINT);
      o_self_print <= (nxt_state == ST_SELF_PRINT);
      o_feed_motor <= (nxt_state == ST_LOAD) || (nxt_state == ST_FEED);
      o_cutter_drive <= (nxt_state == ST_INIT_CUT) || (nxt_state == ST_CUT && cfg_ff.cutter_en);
      o_presenter_drive <= (nxt_state == ST_EJECT);
    end
  end

  assign o_busy        = host_ff.busy;
  assign o_fault_n     = host_ff.fault_n;
  assign o_paper_empty = host_ff.paper_empty;
  assign o_dtr         = host_ff.dtr;
  assign o_config      = cfg_ff;

  // Feed key edge and software feed both queue one feed
  logic key_q_ff;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      key_q_ff <= 1'b1;
      feed_req_ff <= 1'b0;
    end else begin
      key_q_ff <= i_feed_key;
      if ((i_feed_key && !key_q_ff) || (wr_fire && awaddr_ff == OFS_CONTROL && wstrb_ff[0]
          && wdata_ff[CTL_FEED])) feed_req_ff <= 1'b1;
      else if (state_ff == ST_FEED || state_ff == ST_ALARM) feed_req_ff <= 1'b0;
    end
  end

  // Event edges for interrupt status
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      out_seen_ff <= 1'b0;
      low_seen_ff <= 1'b0;
      exit_seen_ff <= 1'b0;
    end else begin
      out_seen_ff <= paper_out;
      low_seen_ff <= paper_low;
      exit_seen_ff <= i_exit_paper;
    end
  end

  assign irq_event[IRQ_PAPER_OUT] = paper_out && !out_seen_ff;
  assign irq_event[IRQ_PAPER_LOW] = paper_low && !low_seen_ff;
  assign irq_event[IRQ_TAKEN]     = !i_exit_paper && exit_seen_ff;
  assign irq_event[IRQ_ALARM]     = (nxt_state == ST_ALARM) && (state_ff != ST_ALARM);
  assign irq_event[IRQ_LOADED]    = (state_ff == ST_LOAD) && (nxt_state == ST_CUT);

  // Sticky status: read clears, a new event in the same cycle wins
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      irq_stat_ff <= '0;
      o_irq <= 1'b0;
    end else begin
      irq_stat_ff <= ((rd_fire && i_araddr == OFS_IRQ_STAT) ? '0 : irq_stat_ff) | irq_event;
      o_irq <= |((((rd_fire && i_araddr == OFS_IRQ_STAT) ? '0 : irq_stat_ff) | irq_event) & irq_mask_ff);
    end
  end

  // Write channel: address and data taken in either order
  assign wr_fire = aw_full_ff && w_full_ff && !o_bvalid;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h0;
      wstrb_ff <= 4'h0;
      o_awready <= 1'b1;
      o_wready <= 1'b1;
      o_bvalid <= 1'b0;
      o_bresp <= RESP_OKAY;
    end else begin
      if (i_awvalid && o_awready) begin
        aw_full_ff <= 1'b1;
        awaddr_ff <= i_awaddr;
        o_awready <= 1'b0;
      end
      if (i_wvalid && o_wready) begin
        w_full_ff <= 1'b1;
        wdata_ff <= i_wdata;
        wstrb_ff <= i_wstrb;
        o_wready <= 1'b0;
      end
      if (wr_fire) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        o_bvalid <= 1'b1;
        o_bresp <= (awaddr_ff == OFS_CONTROL || awaddr_ff == OFS_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
      end
      if (o_bvalid && i_bready) begin
        o_bvalid <= 1'b0;
        o_awready <= 1'b1;
        o_wready <= 1'b1;
      end
    end
  end

  // Writable registers
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      control_ff <= RST_CONTROL;
      irq_mask_ff <= RST_IRQ_MASK;
    end else if (wr_fire && wstrb_ff[0]) begin
      if (awaddr_ff == OFS_CONTROL) control_ff[CTL_HOLD] <= wdata_ff[CTL_HOLD];
      if (awaddr_ff == OFS_IRQ_MASK) irq_mask_ff <= wdata_ff[IRQ_N-1:0];
    end
  end

  // Read channel; one read in flight
  assign rd_fire = i_arvalid && o_arready;
  always_ff @(posedge i_clock or negedge i_nrst) begin
    if (!i_nrst) begin
      o_arready <= 1'b1;
      o_rvalid <= 1'b0;
      o_rdata <= 32'h0;
      o_rresp <= RESP_OKAY;
    end else if (rd_fire) begin
      o_arready <= 1'b0;
      o_rvalid <= 1'b1;
      o_rresp <= RESP_OKAY;
      unique case (i_araddr)
        OFS_STATUS:   o_rdata <= {20'h0, 4'(state_ff), host_ff, paper_low, i_exit_paper,
                                  o_print_enable, paper_out};
        OFS_CONFIG:   o_rdata <= {19'h0, cfg_ff};
        OFS_CONTROL:  o_rdata <= {30'h0, control_ff[CTL_FEED] | feed_req_ff, control_ff[CTL_HOLD]};
        OFS_IRQ_STAT: o_rdata <= {27'h0, irq_stat_ff};
        OFS_IRQ_MASK: o_rdata <= {27'h0, irq_mask_ff};
        default: begin
          o_rdata <= 32'h0;
          o_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (o_rvalid && i_rready) begin
      o_rvalid <= 1'b0;
      o_arready <= 1'b1;
    end
  end

  // Checks of the documented behaviour
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_nrst);

  property p_par_out;
    cfg_taken_ff && !cfg_ff.serial && paper_out && state_ff != ST_ALARM |=> o_busy && !o_fault_n && o_paper_empty;
  endproperty
  a_par_out: assert property (p_par_out) else $error("parallel paper out not flagged");

  property p_ser_out;
    cfg_taken_ff && cfg_ff.serial && paper_out |=> o_dtr && !o_busy;
  endproperty
  a_ser_out: assert property (p_ser_out) else $error("serial paper out dtr not busy");

  property p_halt;
    paper_out && state_ff != ST_WAIT_CFG |=> !o_print_enable && !o_feed_motor;
  endproperty
  a_halt: assert property (p_halt) else $error("mechanism running without paper");

  property p_release;
    state_ff == ST_IDLE && !paper_out && !paper_low && !i_alarm |=> o_fault_n && !o_paper_empty && !o_dtr;
  endproperty
  a_release: assert property (p_release) else $error("paper out indication stuck");

  property p_low;
    cfg_taken_ff && cfg_ff.low_en && i_paper_low_sensor |=> o_paper_empty;
  endproperty
  a_low: assert property (p_low) else $error("paper low not reported");

  property p_no_load;
    !cfg_ff.autoload |-> state_ff != ST_LOAD;
  endproperty
  a_no_load: assert property (p_no_load) else $error("auto load while disabled");

  property p_cut_eject;
    state_ff == ST_CUT && nxt_state == ST_EJECT |=> ##[0:2] o_presenter_drive;
  endproperty
  a_cut_eject: assert property (p_cut_eject) else $error("no eject after cut");

  property p_hold_job;
    i_exit_paper && state_ff != ST_PRINT |=> !o_print_enable;
  endproperty
  a_hold_job: assert property (p_hold_job) else $error("job started with paper in exit");

  property p_cfg_fixed;
    cfg_taken_ff && $past(cfg_taken_ff) |-> $stable(cfg_ff);
  endproperty
  a_cfg_fixed: assert property (p_cfg_fixed) else $error("configuration changed while running");

  property p_alarm;
    cfg_taken_ff && i_alarm |=> !o_fault_n && !o_cutter_drive && !o_feed_motor && !o_presenter_drive;
  endproperty
  a_alarm: assert property (p_alarm) else $error("alarm did not stop control");

  c_paper_cycle: cover property (state_ff == ST_PAPER_OUT ##[1:50] state_ff == ST_LOAD);
  c_feed_key:    cover property (state_ff == ST_FEED ##[1:100] state_ff == ST_EJECT);
  c_wait_take:   cover property (state_ff == ST_WAIT_TAKE ##1 state_ff == ST_IDLE);
  c_self_print:  cover property (state_ff == ST_SELF_PRINT);

endmodule

/* File: pcfg_host_model.sv */
// Host computer model watching the printer's flow-control pins.
// Assumes pins are registered outputs of the block on the same clock.
module pcfg_host_model (
  input  wire logic i_clock,
  input  wire logic i_serial,
  input  wire logic i_busy,
  input  wire logic i_fault_n,
  input  wire logic i_dtr,
  output logic      o_may_send
);
  timeunit 1ns;
  timeprecision 1ns;
  // Host sends only while the selected port reports ready; parallel also needs no fault
  always_ff @(posedge i_clock) begin
    o_may_send <= i_serial ? !i_dtr : (!i_busy && i_fault_n);
  end
endmodule

/* File: printer_paper_and_config_control_test.sv */
// Self-checking bench of the paper and config control block.
// Assumes short mechanism counts; host model sits on the status pins.
module printer_paper_and_config_control_test;
  import pcfg_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clock = 0, i_nrst = 0, pend = 0, plow = 0, lever = 1, key = 0, home = 0;
  logic exitp = 0, alarm = 0, bufd = 1, pdone = 0, awv = 0, wv = 0, bre = 0, arv = 0, rre = 0, creq = 0;
  logic [3:0] ws = 4'hF;
  logic [7:0] sw1 = 8'h01, sw2 = 8'h00, awa = 8'h00, ara = 8'h00;
  logic [31:0] wd = 32'h0, rd;
  logic [1:0] rs;
  logic busy, fault_n, pe, dtr, pen, selfp, feed, cut, pres, irq, awr, wr, bv, arr, rv, may_send;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  pcfg_cfg_t cfg, exp_cfg;
  int n_fail = 0, samples_checked = 0, cycles = 0, k;
  // Short counts keep each sequence a few cycles long
  pcfg_ctrl #(.P_LOAD_CYCLES(20), .P_FEED_CYCLES(10), .P_CUT_CYCLES(10), .P_EJECT_CYCLES(10)) dut_u (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_switch_bank_one(sw1), .i_switch_bank_two(sw2),
    .i_paper_end(pend), .i_paper_low_sensor(plow), .i_head_lever_down(lever), .i_feed_key(key),
    .i_cutter_home(home), .i_exit_paper(exitp), .i_alarm(alarm), .i_buffer_data(bufd),
    .i_cut_request(creq), .i_print_done(pdone), .o_busy(busy), .o_fault_n(fault_n),
    .o_paper_empty(pe), .o_dtr(dtr), .o_print_enable(pen), .o_self_print(selfp), .o_feed_motor(feed),
    .o_cutter_drive(cut), .o_presenter_drive(pres), .o_config(cfg), .o_irq(irq),
    .i_awvalid(awv), .o_awready(awr), .i_awaddr(awa), .i_wvalid(wv), .o_wready(wr), .i_wdata(wd),
    .i_wstrb(ws), .o_bvalid(bv), .i_bready(bre), .o_bresp(bresp), .i_arvalid(arv), .o_arready(arr),
    .i_araddr(ara), .o_rvalid(rv), .i_rready(rre), .o_rdata(rdata), .o_rresp(rresp));
  pcfg_host_model host_u (.i_clock(i_clock), .i_serial(cfg.serial), .i_busy(busy), .i_fault_n(fault_n),
    .i_dtr(dtr), .o_may_send(may_send));
  // Clock and hang guard
  initial begin
    forever #25 i_clock = ~i_clock;
  end
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic sig(input int s);
    case (s)
      0: return feed;
      1: return cut;
      2: return pres;
      3: return pen;
      4: return busy;
      5: return selfp;
      default: return irq;
    endcase
  endfunction
  // Bounded wait on one output, then judge its level
  task automatic wait_for(input int s, input logic v, input string nm);
    for (k = 0; k < 200 && sig(s) !== v; k++) @(posedge i_clock);
    chk(nm, sig(s), v);
  endtask
  // Write offers address and data together, releases each when taken
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    awv <= 1; awa <= a; wv <= 1; wd <= d; bre <= 1;
    // No cycle count assumed; the hang guard ends a stuck wait
    do begin
      @(posedge i_clock);
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
    end while (!bv);
    rs = bresp;
    bre <= 0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge i_clock);
    arv <= 1; ara <= a; rre <= 1;
    do begin
      @(posedge i_clock);
      if (arv && arr) arv <= 0;
    end while (!rv);
    rd = rdata;
    rs = rresp;
    rre <= 0;
  endtask
  // Reset with given switches; cutter homes against a late home sensor
  task automatic do_reset(input logic [7:0] s1, input logic [7:0] s2, input logic kd);
    sw1 <= s1; sw2 <= s2; key <= kd; home <= 0; i_nrst <= 0;
    repeat (8) @(posedge i_clock);
    i_nrst <= 1;
    repeat (3) @(posedge i_clock);
    chk("homing_drive", cut, 1'b1);
    home <= 1;
    wait_for(1, 1'b0, "homing_done");
    repeat (2) @(posedge i_clock);
  endtask
  task automatic t_config;
    for (int c = 0; c < 16; c++) begin
      do_reset({c[3:0], c[0], c[1], 2'b01}, {1'b0, c[2], c[3], 1'b0, c[0], 2'b00, c[1]}, 0);
      exp_cfg = '{serial: c != 0, baud: 3'((c + 4) % 5), parity: 2'((c + 4) / 5 - 1), density: {c[1], c[3]},
                  autoload: c[0], low_en: c[1], cutter_en: 1'b1, xon_mode: c[0], data8: c[2]};
      // Parallel port leaves baud and parity at their zero codes
      if (c == 0) {exp_cfg.baud, exp_cfg.parity} = {3'h0, PAR_NONE};
      chk("port_select", cfg.serial, c != 0);
      if (c != 0) chk("config", cfg, exp_cfg);
      else chk("config_low", cfg[7:0], exp_cfg[7:0]);
    end
    sw1 <= 8'h00;
    sw2 <= 8'hFF;
    repeat (4) @(posedge i_clock);
    chk("config_held", cfg, exp_cfg);
    axi_rd(OFS_CONFIG);
    chk("config_reg", rd, {19'h0, exp_cfg});
  endtask
  // Parallel paper out held, then replaced with auto-load off
  task automatic t_paper_par;
    do_reset(8'h01, 8'h00, 0);
    pend <= 1;
    wait_for(4, 1'b1, "busy_out");
    repeat (6) @(posedge i_clock);
    chk("pins_out", {busy, fault_n, pe, pen, may_send}, 5'b10100);
    pend <= 0;
    wait_for(4, 1'b0, "busy_back");
    chk("pins_back", {fault_n, pe, feed}, 3'b100);
    wait_for(3, 1'b1, "resume");
    // Engine ends the job with a cut; presenter must follow
    creq <= 1;
    wait_for(2, 1'b1, "job_eject");
    creq <= 0;
  endtask
  task automatic t_paper_ser;
    do_reset(8'h11, 8'h01, 0);
    axi_rd(OFS_IRQ_MASK);
    chk("mask_reset", rd, 32'h0);
    plow <= 1;
    repeat (4) @(posedge i_clock);
    chk("low_masked", {pe, irq}, 2'b10);
    axi_wr(OFS_IRQ_MASK, 32'h2);
    wait_for(6, 1'b1, "irq_low");
    plow <= 0;
    axi_rd(OFS_IRQ_STAT);
    chk("stat_low", rd[IRQ_PAPER_LOW], 1'b1);
    axi_rd(OFS_IRQ_STAT);
    chk("stat_clear", rd[IRQ_PAPER_LOW], 1'b0);
    wait_for(6, 1'b0, "irq_drop");
    pend <= 1;
    repeat (4) @(posedge i_clock);
    chk("dtr_out", {dtr, busy, may_send}, 3'b100);
    pend <= 0;
    repeat (4) @(posedge i_clock);
    chk("dtr_back", dtr, 1'b0);
    axi_rd(8'h14);
    chk("unmapped", rs, RESP_SLVERR);
    axi_wr(OFS_STATUS, 32'hFFFF);
    chk("ro_write", rs, RESP_SLVERR);
    ws <= 4'h0;
    axi_wr(OFS_IRQ_MASK, 32'h0);
    ws <= 4'hF;
    axi_rd(OFS_IRQ_MASK);
    chk("strobe_off", rd, 32'h2);
  endtask
  // Feed key: feed, cut, eject, then hold until paper taken
  task automatic t_feed;
    // Empty buffer so the sequencer returns to idle and takes the key
    bufd <= 0;
    key <= 1;
    wait_for(0, 1'b1, "feed");
    key <= 0;
    wait_for(1, 1'b1, "cut");
    wait_for(2, 1'b1, "eject");
    exitp <= 1;
    wait_for(2, 1'b0, "eject_end");
    bufd <= 1;
    repeat (8) @(posedge i_clock);
    chk("held", pen, 1'b0);
    exitp <= 0;
    wait_for(3, 1'b1, "taken");
  endtask
  task automatic t_autoload;
    int n;
    do_reset(8'h01, 8'h08, 0);
    pend <= 1;
    lever <= 0;
    wait_for(4, 1'b1, "busy_load");
    pend <= 0;
    // Lever still up: no load feed, paper-out pins held
    repeat (20) @(posedge i_clock);
    chk("lever_gate", feed, 1'b0);
    chk("lever_busy", busy, 1'b1);
    lever <= 1;
    wait_for(0, 1'b1, "load_feed");
    for (n = 0; n < 100 && feed === 1'b1; n++) @(posedge i_clock);
    chk("load_len", n, 20);
    wait_for(2, 1'b1, "load_eject");
    wait_for(3, 1'b1, "load_ready");
  endtask
  task automatic t_self_alarm;
    do_reset(8'h01, 8'h00, 1);
    wait_for(5, 1'b1, "self_print");
    pdone <= 1;
    @(posedge i_clock);
    pdone <= 0;
    key <= 0;
    wait_for(5, 1'b0, "self_done");
    alarm <= 1;
    repeat (3) @(posedge i_clock);
    key <= 1;
    repeat (30) @(posedge i_clock);
    chk("alarm_stop", {fault_n, feed, cut, pres, pen}, 5'b0);
    alarm <= 0;
    key <= 0;
  endtask
  task automatic report_and_stop;
    if (n_fail == 0 && samples_checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    t_config();
    t_paper_par();
    t_feed();
    t_paper_ser();
    t_autoload();
    t_self_alarm();
    report_and_stop();
  end
endmodule
